// ===== t16_pkg.sv
// Shared constants, types and decode functions for the 16-bit timer block.
package t16_pkg;

    // Register addresses on the 8-bit I/O bus.
    localparam logic [5:0] ADDR_CTRL_A = 6'h2E;
    localparam logic [5:0] ADDR_CTRL_B = 6'h2D;
    localparam logic [5:0] ADDR_CTRL_C = 6'h2C;
    localparam logic [5:0] ADDR_CNT_H = 6'h29;
    localparam logic [5:0] ADDR_CNT_L = 6'h28;
    localparam logic [5:0] ADDR_CMPA_H = 6'h27;
    localparam logic [5:0] ADDR_CMPA_L = 6'h26;
    localparam logic [5:0] ADDR_CMPB_H = 6'h25;
    localparam logic [5:0] ADDR_CMPB_L = 6'h24;
    localparam logic [5:0] ADDR_CAP_H = 6'h23;
    localparam logic [5:0] ADDR_CAP_L = 6'h22;

    // Reset values and writable-bit masks.
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] HOLD_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] CTRL_A_MASK = 8'hF3;
    localparam logic [7:0] CTRL_B_MASK = 8'hDF;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Field positions.
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int WGM_LO_LSB = 0;
    localparam int WGM_HI_LSB = 3;
    localparam int CS_LSB = 0;
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;

    // Fixed TOP values.
    localparam logic [15:0] TOP_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;

    typedef enum logic [2:0] {
        T16_CLS_NORMAL,
        T16_CLS_CTC,
        T16_CLS_FAST,
        T16_CLS_PC,
        T16_CLS_PFC
    } t16_cls_t;

    // Reserved mode 13 behaves as a plain free-running counter.
    function automatic t16_cls_t t16_mode_class(input logic [3:0] wgm);
        case (wgm)
            4'h1, 4'h2, 4'h3, 4'hA, 4'hB: t16_mode_class = T16_CLS_PC;
            4'h4, 4'hC: t16_mode_class = T16_CLS_CTC;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: t16_mode_class = T16_CLS_FAST;
            4'h8, 4'h9: t16_mode_class = T16_CLS_PFC;
            default: t16_mode_class = T16_CLS_NORMAL;
        endcase
    endfunction : t16_mode_class

    function automatic logic t16_top_from_capture(input logic [3:0] wgm);
        t16_top_from_capture = (wgm == 4'h8) || (wgm == 4'hA) || (wgm == 4'hC) || (wgm == 4'hE);
    endfunction : t16_top_from_capture

    function automatic logic t16_top_from_cmp_a(input logic [3:0] wgm);
        t16_top_from_cmp_a = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hB) || (wgm == 4'hF);
    endfunction : t16_top_from_cmp_a

    function automatic logic t16_is_high_addr(input logic [5:0] addr);
        t16_is_high_addr = (addr == ADDR_CNT_H) || (addr == ADDR_CMPA_H) || (addr == ADDR_CMPB_H)
            || (addr == ADDR_CAP_H);
    endfunction : t16_is_high_addr

endpackage : t16_pkg

// ===== t16_chan_if.sv
// Events and settings passed from the timer core to one compare output unit.
`timescale 1ns/10ps
interface t16_chan_if;
    import t16_pkg::*;
    logic match;
    logic bottom;
    logic up;
    logic force_cmp;
    logic top_eq;
    logic mode_bit3;
    logic is_b;
    logic [1:0] action;
    t16_cls_t cls;
    logic oc;

    modport core (output match, bottom, up, force_cmp, top_eq, mode_bit3, is_b, action, cls, input oc);
    modport unit (input match, bottom, up, force_cmp, top_eq, mode_bit3, is_b, action, cls, output oc);
endinterface : t16_chan_if

// ===== t16_compare_unit.sv
// Compare output action logic for one channel.
`timescale 1ns/10ps
module t16_compare_unit
    import t16_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    t16_chan_if.unit ch
);
    logic oc_q;
    logic toggle_ok;

    assign ch.oc = oc_q;
    // Channel B has no toggle in PWM modes; that setting is reserved and leaves it still.
    assign toggle_ok = ch.mode_bit3 && !ch.is_b;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            oc_q <= 1'b0;
        end
        else
        begin
            case (ch.cls)
                T16_CLS_NORMAL, T16_CLS_CTC:
                begin
                    if (ch.match || ch.force_cmp)
                    begin
                        case (ch.action)
                            2'h1: oc_q <= ~oc_q;
                            2'h2: oc_q <= 1'b0;
                            2'h3: oc_q <= 1'b1;
                            default: oc_q <= oc_q;
                        endcase
                    end
                end
                T16_CLS_FAST:
                begin
                    if (ch.action == 2'h1)
                    begin
                        if (toggle_ok && ch.match)
                        begin
                            oc_q <= ~oc_q;
                        end
                    end
                    else if (ch.action[1])
                    begin
                        if (ch.bottom)
                        begin
                            oc_q <= ~ch.action[0];
                        end
                        else if (ch.match && !ch.top_eq)
                        begin
                            oc_q <= ch.action[0];
                        end
                    end
                end
                T16_CLS_PC, T16_CLS_PFC:
                begin
                    if (ch.action == 2'h1)
                    begin
                        if (toggle_ok && ch.match)
                        begin
                            oc_q <= ~oc_q;
                        end
                    end
                    else if (ch.action[1] && ch.match)
                    begin
                        oc_q <= ch.up ? ch.action[0] : ~ch.action[0];
                    end
                end
                default: oc_q <= oc_q;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_nonpwm_toggle;
        ((ch.cls == T16_CLS_NORMAL) && ch.match && (ch.action == 2'h1)) |=> (oc_q != $past(oc_q));
    endproperty
    a_nonpwm_toggle: assert property (p_nonpwm_toggle) else $error("Non-PWM toggle did not toggle.");

    property p_fast_bottom;
        ((ch.cls == T16_CLS_FAST) && ch.bottom && ch.action[1]) |=> (oc_q == ~$past(ch.action[0]));
    endproperty
    a_fast_bottom: assert property (p_fast_bottom) else $error("Fast PWM bottom action wrong.");

    property p_fast_top_ignored;
        ((ch.cls == T16_CLS_FAST) && ch.match && ch.top_eq && ch.bottom && ch.action[1])
            |=> (oc_q == ~$past(ch.action[0]));
    endproperty
    a_fast_top_ignored: assert property (p_fast_top_ignored) else $error("Match at TOP was not ignored.");

    property p_dual_slope;
        (((ch.cls == T16_CLS_PC) || (ch.cls == T16_CLS_PFC)) && ch.match && ch.action[1])
            |=> (oc_q == ($past(ch.up) ~^ $past(ch.action[0])));
    endproperty
    a_dual_slope: assert property (p_dual_slope) else $error("Dual-slope match action wrong.");

    property p_pwm_reserved_b;
        ((ch.cls != T16_CLS_NORMAL) && (ch.cls != T16_CLS_CTC) && ch.is_b && (ch.action == 2'h1)) |=> $stable(oc_q);
    endproperty
    a_pwm_reserved_b: assert property (p_pwm_reserved_b) else $error("Channel B moved in a reserved setting.");

endmodule : t16_compare_unit

// ===== t16_timer.sv
// 16-bit timer core: byte-wide register access, counter and compare output pins.
`timescale 1ns/10ps
module t16_timer
    import t16_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic timer_tick,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic capture_event,
    input wire logic dir_a,
    input wire logic dir_b,
    input wire logic port_data_a,
    input wire logic port_data_b,
    output logic pin_a_out,
    output logic pin_a_oe,
    output logic pin_b_out,
    output logic pin_b_oe
);
    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_b_q;
    logic [7:0] hold_q;
    logic [7:0] rdata_q;
    logic [15:0] count_q;
    logic [15:0] cap_q;
    logic [15:0] buf_a_q;
    logic [15:0] buf_b_q;
    logic [15:0] act_a_q;
    logic [15:0] act_b_q;
    logic up_q;
    logic block_q;
    logic [3:0] wgm;
    t16_cls_t cls;
    logic pwm;
    logic tick;
    logic [15:0] top_val;
    logic at_top;
    logic at_bottom;
    logic cnt_wr;
    logic load_cmp;
    logic [1:0] act_sel_a;
    logic [1:0] act_sel_b;

    t16_chan_if ch_a ();
    t16_chan_if ch_b ();

    assign wgm = {ctrl_b_q[WGM_HI_LSB +: 2], ctrl_a_q[WGM_LO_LSB +: 2]};
    assign cls = t16_mode_class(wgm);
    assign pwm = (cls == T16_CLS_FAST) || (cls == T16_CLS_PC) || (cls == T16_CLS_PFC);
    // The tick only enables; a stopped clock select holds the counter still.
    assign tick = timer_tick && (ctrl_b_q[CS_LSB +: 3] != 3'h0);
    assign at_bottom = (count_q == WORD_RST);
    assign at_top = (count_q == top_val);
    assign cnt_wr = io_wr && (io_addr == ADDR_CNT_L);
    assign act_sel_a = ctrl_a_q[ACT_A_LSB +: 2];
    assign act_sel_b = ctrl_a_q[ACT_B_LSB +: 2];

    always_comb
    begin
        if (t16_top_from_capture(wgm))
            top_val = cap_q;
        else if (t16_top_from_cmp_a(wgm))
            top_val = act_a_q;
        else if (wgm[1:0] == 2'h1 && !wgm[3])
            top_val = TOP_8BIT;
        else if (wgm[1:0] == 2'h2 && !wgm[3])
            top_val = TOP_9BIT;
        else if (wgm[1:0] == 2'h3 && !wgm[3])
            top_val = TOP_10BIT;
        else
            top_val = TOP_MAX;
    end

    // Control registers; reserved bits are not stored and read as zero.
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_a_q <= CTRL_A_RST;
            ctrl_b_q <= CTRL_B_RST;
        end
        else if (io_wr && (io_addr == ADDR_CTRL_A))
            ctrl_a_q <= io_wdata & CTRL_A_MASK;
        else if (io_wr && (io_addr == ADDR_CTRL_B))
            ctrl_b_q <= io_wdata & CTRL_B_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            hold_q <= HOLD_RST;
        else if (io_wr && t16_is_high_addr(io_addr))
            hold_q <= io_wdata;
        else if (io_rd && (io_addr == ADDR_CNT_L))
            hold_q <= count_q[15:8];
        else if (io_rd && (io_addr == ADDR_CAP_L))
            hold_q <= cap_q[15:8];
    end

    // Read data is registered: it is valid on the cycle after the read strobe.
    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_q <= READ_ZERO;
        else if (io_rd)
        begin
            case (io_addr)
                ADDR_CTRL_A: rdata_q <= ctrl_a_q;
                ADDR_CTRL_B: rdata_q <= ctrl_b_q;
                ADDR_CNT_L: rdata_q <= count_q[7:0];
                ADDR_CNT_H: rdata_q <= hold_q;
                ADDR_CMPA_L: rdata_q <= buf_a_q[7:0];
                ADDR_CMPA_H: rdata_q <= buf_a_q[15:8];
                ADDR_CMPB_L: rdata_q <= buf_b_q[7:0];
                ADDR_CMPB_H: rdata_q <= buf_b_q[15:8];
                ADDR_CAP_L: rdata_q <= cap_q[7:0];
                ADDR_CAP_H: rdata_q <= hold_q;
                default: rdata_q <= READ_ZERO;
            endcase
        end
    end
    assign io_rdata = rdata_q;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count_q <= WORD_RST;
            up_q <= 1'b1;
        end
        else if (cnt_wr)
            count_q <= {hold_q, io_wdata};
        else if (tick)
        begin
            case (cls)
                T16_CLS_CTC, T16_CLS_FAST:
                begin
                    count_q <= at_top ? WORD_RST : count_q + 16'h0001;
                    up_q <= 1'b1;
                end
                T16_CLS_PC, T16_CLS_PFC:
                begin
                    if (up_q && (count_q >= top_val))
                    begin
                        count_q <= count_q - 16'h0001;
                        up_q <= 1'b0;
                    end
                    else if (!up_q && at_bottom)
                    begin
                        count_q <= count_q + 16'h0001;
                        up_q <= 1'b1;
                    end
                    else
                        count_q <= up_q ? count_q + 16'h0001 : count_q - 16'h0001;
                end
                default:
                begin
                    count_q <= count_q + 16'h0001;
                    up_q <= 1'b1;
                end
            endcase
        end
    end

    // A count write suppresses compare matches on the next timer tick.
    always_ff @(posedge clk)
    begin
        if (srst)
            block_q <= 1'b0;
        else if (cnt_wr)
            block_q <= 1'b1;
        else if (tick)
            block_q <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            buf_a_q <= WORD_RST;
            buf_b_q <= WORD_RST;
        end
        else if (io_wr && (io_addr == ADDR_CMPA_L))
            buf_a_q <= {hold_q, io_wdata};
        else if (io_wr && (io_addr == ADDR_CMPB_L))
            buf_b_q <= {hold_q, io_wdata};
    end

    // Non-PWM modes follow the buffer one cycle later; PWM modes load at TOP or BOTTOM.
    assign load_cmp = !pwm || (tick && (cls == T16_CLS_PFC) && at_bottom)
        || (tick && (cls != T16_CLS_PFC) && at_top);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            act_a_q <= WORD_RST;
            act_b_q <= WORD_RST;
        end
        else if (load_cmp)
        begin
            act_a_q <= buf_a_q;
            act_b_q <= buf_b_q;
        end
    end

    // Capture is disabled while the capture register defines TOP.
    always_ff @(posedge clk)
    begin
        if (srst)
            cap_q <= WORD_RST;
        else if (io_wr && (io_addr == ADDR_CAP_L))
            cap_q <= {hold_q, io_wdata};
        else if (capture_event && !t16_top_from_capture(wgm))
            cap_q <= count_q;
    end

    assign ch_a.match = tick && !block_q && (count_q == act_a_q);
    assign ch_b.match = tick && !block_q && (count_q == act_b_q);
    assign ch_a.bottom = tick && (cls == T16_CLS_FAST) && at_top;
    assign ch_b.bottom = tick && (cls == T16_CLS_FAST) && at_top;
    assign ch_a.up = up_q;
    assign ch_b.up = up_q;
    assign ch_a.force_cmp = io_wr && (io_addr == ADDR_CTRL_C) && io_wdata[FORCE_A_BIT] && !pwm;
    assign ch_b.force_cmp = io_wr && (io_addr == ADDR_CTRL_C) && io_wdata[FORCE_B_BIT] && !pwm;
    assign ch_a.top_eq = (act_a_q == top_val);
    assign ch_b.top_eq = (act_b_q == top_val);
    assign ch_a.mode_bit3 = wgm[3];
    assign ch_b.mode_bit3 = wgm[3];
    assign ch_a.is_b = 1'b0;
    assign ch_b.is_b = 1'b1;
    assign ch_a.action = act_sel_a;
    assign ch_b.action = act_sel_b;
    assign ch_a.cls = cls;
    assign ch_b.cls = cls;

    t16_compare_unit u_cmp_a (
        .clk(clk),
        .srst(srst),
        .ch(ch_a.unit)
    );

    t16_compare_unit u_cmp_b (
        .clk(clk),
        .srst(srst),
        .ch(ch_b.unit)
    );

    // Without mode bit 3, PWM setting 01 hands the pin back to the port just as setting 00 does.
    function automatic logic t16_pin_connected(input logic [1:0] act, input logic pwm_mode, input logic bit3);
        t16_pin_connected = (act != 2'h0) && !(pwm_mode && (act == 2'h1) && !bit3);
    endfunction : t16_pin_connected

    assign pin_a_out = t16_pin_connected(act_sel_a, pwm, wgm[3]) ? ch_a.oc : port_data_a;
    assign pin_b_out = t16_pin_connected(act_sel_b, pwm, wgm[3]) ? ch_b.oc : port_data_b;
    assign pin_a_oe = dir_a;
    assign pin_b_oe = dir_b;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_low_write;
        (io_wr && (io_addr == ADDR_CNT_L)) |=> (count_q == {$past(hold_q), $past(io_wdata)});
    endproperty
    a_low_write: assert property (p_low_write) else $error("Low write did not merge holding byte.");

    sequence s_low_read;
        io_rd && (io_addr == ADDR_CNT_L) && !io_wr;
    endsequence
    sequence s_high_read;
        io_rd && (io_addr == ADDR_CNT_H) && !io_wr;
    endsequence
    property p_read_pair;
        logic [7:0] hi;
        (s_low_read, hi = count_q[15:8]) ##1 (!io_rd && !io_wr) [*2] ##1 s_high_read |=> (rdata_q == hi);
    endproperty
    a_read_pair: assert property (p_read_pair) else $error("High read lost the captured byte.");

    property p_cmp_read;
        (io_rd && !io_wr && ((io_addr == ADDR_CMPA_H) || (io_addr == ADDR_CMPA_L)))
            |=> $stable(hold_q) && (rdata_q == ($past(io_addr) == ADDR_CMPA_H ? $past(buf_a_q[15:8])
            : $past(buf_a_q[7:0])));
    endproperty
    a_cmp_read: assert property (p_cmp_read) else $error("Compare read disturbed holding register.");

    property p_hold_keep;
        !(io_wr && t16_is_high_addr(io_addr)) && !(io_rd && ((io_addr == ADDR_CNT_L) || (io_addr == ADDR_CAP_L)))
            |=> $stable(hold_q);
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("Holding register changed unasked.");

    property p_pfc_load;
        (tick && (cls == T16_CLS_PFC) && !at_bottom) |=> $stable(act_a_q) && $stable(act_b_q);
    endproperty
    a_pfc_load: assert property (p_pfc_load) else $error("Compare loaded away from BOTTOM.");

    property p_stopped;
        ((ctrl_b_q[CS_LSB +: 3] == 3'h0) && !cnt_wr) |=> $stable(count_q);
    endproperty
    a_stopped: assert property (p_stopped) else $error("Counter moved with no clock select.");

    property p_pin_drive;
        (pin_a_oe == dir_a) && ((act_sel_a != 2'h0) || (pin_a_out == port_data_a))
            && (!act_sel_a[1] || (pin_a_out == ch_a.oc));
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("Pin A drive wrong.");

endmodule : t16_timer

// ===== t16_cpu_model.sv
// Behavioural CPU that reaches the timer through its byte-wide register bus.
`timescale 1ns/10ps
module t16_cpu_model (
    input wire logic clk,
    output logic [5:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata
);
    initial
    begin
        io_addr = 6'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    // The data byte is inverted once released so that a stale value is never mistaken for a live one.
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        io_addr <= a;
        io_wr <= w;
        io_rd <= ~w;
        io_wdata <= d;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        io_wdata <= ~d;
        @(posedge clk);
        q = io_rdata;
    endtask : acc

    // A 16-bit access always runs to its end before another starts, so the holding byte is never shared.
    task automatic wr16(input logic [5:0] a, input logic [15:0] v);
        logic [7:0] q;
        acc(1'b1, a + 6'h01, v[15:8], q);
        acc(1'b1, a, v[7:0], q);
    endtask : wr16

    task automatic rd16(input logic [5:0] a, output logic [15:0] v);
        acc(1'b0, a, 8'h00, v[7:0]);
        acc(1'b0, a + 6'h01, 8'h00, v[15:8]);
    endtask : rd16
endmodule : t16_cpu_model

// ===== timer16_access_compare_output_tb.sv
// Self-checking testbench for the 16-bit timer block.
`timescale 1ns/10ps
module timer16_access_compare_output_tb;
    import t16_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic timer_tick = 1'b1;
    logic tick_half = 1'b0;
    logic dir_a = 1'b1;
    logic dir_b = 1'b0;
    logic port_data_a = 1'b0;
    logic port_data_b = 1'b0;
    logic [5:0] io_addr;
    logic io_wr;
    logic io_rd;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic pin_a_out;
    logic pin_a_oe;
    logic pin_b_out;
    logic pin_b_oe;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] seed = 32'hE07E;
    logic [15:0] v;
    logic [15:0] q16;
    logic [7:0] q;
    logic [7:0] c;
    logic [7:0] x;

    always #5 clk = ~clk;
    always @(posedge clk) timer_tick <= tick_half ? ~timer_tick : 1'b1;

    t16_timer DUT (.clk(clk), .srst(srst), .timer_tick(timer_tick), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .capture_event(1'b0), .dir_a(dir_a),
        .dir_b(dir_b), .port_data_a(port_data_a), .port_data_b(port_data_b), .pin_a_out(pin_a_out),
        .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
    t16_cpu_model cpu (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Toggle is expected high because the table is walked from set to clear to toggle.
    function automatic logic exp_act(input logic [1:0] k, input logic p);
        return (k == 2'd0) ? p : (k != 2'd2);
    endfunction : exp_act

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [15:0] cmp);
        cpu.acc(1'b1, ADDR_CTRL_B, 8'h00, q);
        cpu.wr16(ADDR_CNT_L, 16'h0000);
        cpu.wr16(ADDR_CAP_L, 16'h00FF);
        cpu.wr16(ADDR_CMPA_L, cmp);
        cpu.acc(1'b1, ADDR_CTRL_A, a, q);
        cpu.acc(1'b1, ADDR_CTRL_B, b, q);
    endtask : cfg

    // Counting high cycles over whole periods avoids sampling the counter while it runs.
    task automatic duty(input logic [7:0] a, input logic [7:0] b, input logic [15:0] cmp, input int cyc,
        input int e);
        int hi;
        hi = 0;
        cfg(a, b, cmp);
        repeat (1200) @(posedge clk);
        repeat (cyc)
        begin
            @(posedge clk);
            #1;
            hi += int'(pin_a_out);
        end
        check_count++;
        if (hi > e + 4 || hi + 4 < e)
        begin
            num_errors++;
            $display("CHECK FAILED duty a=%h b=%h expected %0d seen %0d", a, b, e, hi);
        end
    endtask : duty

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial
    begin
        #400000;
        num_errors++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        final_report();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        cpu.acc(1'b0, ADDR_CTRL_A, 8'h00, q);
        chk("ctrl_a reset", 16'h0000, {8'h00, q});
        seed = lfsr_next(seed);
        cpu.acc(1'b1, ADDR_CNT_L, seed[7:0], q);
        cpu.rd16(ADDR_CNT_L, q16);
        chk("count low only", {8'h00, seed[7:0]}, q16);
        for (int i = 0; i < 24; i++)
        begin
            seed = lfsr_next(seed);
            v = seed[15:0];
            cpu.wr16(ADDR_CAP_L + 6'(2 * (i % 4)), v);
            cpu.rd16(ADDR_CAP_L + 6'(2 * (i % 4)), q16);
            chk("word readback", v, q16);
        end
        x = seed[23:16];
        cpu.acc(1'b1, ADDR_CNT_H, x, q);
        cpu.acc(1'b1, ADDR_CMPA_L, 8'h5A, q);
        cpu.rd16(ADDR_CNT_L, q16);
        chk("count after high write", v, q16);
        cpu.rd16(ADDR_CMPA_L, q16);
        chk("compare a shared high", {x, 8'h5A}, q16);
        cpu.acc(1'b0, ADDR_CNT_L, 8'h00, q);
        cpu.acc(1'b0, ADDR_CMPA_H, 8'h00, q);
        chk("compare a high direct", {8'h00, x}, {8'h00, q});
        cpu.acc(1'b0, ADDR_CNT_H, 8'h00, q);
        chk("count high held", {8'h00, v[15:8]}, {8'h00, q});
        cpu.acc(1'b1, ADDR_CTRL_A, 8'hFF, q);
        cpu.acc(1'b0, ADDR_CTRL_A, 8'h00, q);
        chk("ctrl_a fields", 16'h00F3, {8'h00, q});
        cpu.acc(1'b0, 6'h3F, 8'h00, q);
        chk("unmapped read", 16'h0000, {8'h00, q});
        for (int k = 3; k >= 0; k--)
        begin
            cfg(8'(k << 6), 8'h01, 16'h0005);
            repeat (20) @(posedge clk);
            seed = lfsr_next(seed);
            dir_a <= seed[0];
            port_data_a <= seed[1];
            dir_b <= seed[2];
            port_data_b <= seed[3];
            @(posedge clk);
            #1;
            chk("pin a", exp_act(2'(k), port_data_a), pin_a_out);
            chk("pin a enable", dir_a, pin_a_oe);
            chk("pin b", {dir_b, port_data_b}, {pin_b_oe, pin_b_out});
        end
        cfg(8'h80, 8'h00, 16'h0005);
        chk("before force a", 16'h0001, {15'h0000, pin_a_out});
        cpu.acc(1'b1, ADDR_CTRL_C, 8'h80, q);
        chk("forced clear a", 16'h0000, {15'h0000, pin_a_out});
        cpu.acc(1'b0, ADDR_CTRL_C, 8'h00, q);
        chk("ctrl_c reads zero", 16'h0000, {8'h00, q});
        cfg(8'h41, 8'h09, 16'h0080);
        #1;
        chk("pwm action 01 low mode", port_data_a, pin_a_out);
        dir_a <= 1'b1;
        c = {1'b0, seed[14:8]} | 8'h01;
        duty(8'h81, 8'h09, c, 1024, 4 * c + 4);
        duty(8'hC1, 8'h09, c, 1024, 1020 - 4 * c);
        duty(8'h81, 8'h09, 16'h00FF, 1024, 1024);
        duty(8'h81, 8'h01, c, 1020, 4 * c + 2);
        duty(8'hC1, 8'h01, c, 1020, 1018 - 4 * c);
        duty(8'h80, 8'h11, c, 1020, 4 * c + 2);
        duty(8'h53, 8'h19, 16'h007F, 1024, 512);
        tick_half <= 1'b1;
        duty(8'h81, 8'h09, c, 2048, 8 * c + 8);
        final_report();
    end
endmodule : timer16_access_compare_output_tb
